// [logic/npc_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
`include "npc_params.svh"
module npc_ctrl #(
  parameter int NUM_SRC = `NPC_NUM_SRC
) (
  input  wire logic                  core_clk,          // bus clock
  input  wire logic                  resetn,            // async reset, low
  input  wire npc_pkg::npc_wb_req_type wbReq,           // wishbone request
  output var npc_pkg::npc_wb_rsp_type  wbRsp,           // wishbone answer
  input  wire logic [NUM_SRC-1:0]    srcReq,            // source requests
  input  wire logic [`NPC_RESET_CAUSES-1:0] resetCause, // reset causes
  input  wire logic                  stopMode,          // lowest-power stop
  input  wire logic                  vectorFetchStrobe, // core fetches vector
  input  wire logic [`NPC_VEC_W-1:0] fetchVector,       // vector fetched
  output logic [NUM_SRC-1:0]         gatedRequestOut,   // requests to core
  output logic                       pendingValid,      // a request pending
  output logic [`NPC_VEC_W-1:0]      pendingVector,     // most urgent vector
  output logic [15:0]                pendingVecAddr,    // its table address
  output logic                       resetVectorReq     // reset vector taken
);

  localparam int LVL_WORDS = (NUM_SRC + `NPC_LEVELS_PER_WORD - 1) /
                             `NPC_LEVELS_PER_WORD;

  // helpers

  function automatic logic [`NPC_ADR_W-1:0] level_offset(input int w);
    level_offset = `NPC_ADR_W'(`NPC_OFS_LEVEL + 4 * w);
  endfunction

  function automatic logic [15:0] vec_addr(
    input logic [`NPC_VEC_W-1:0] vec
  );
    vec_addr = `NPC_VEC_TOP_ADDR - {9'h000, vec, 1'b0};
  endfunction

  // lowest set index wins: vector 0 is the most urgent
  function automatic logic [`NPC_VEC_W:0] lowest_set(
    input logic [NUM_SRC-1:0] v
  );
    lowest_set = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) lowest_set = {1'b1, `NPC_VEC_W'(i)};
    end
  endfunction

  function automatic logic [3:0] bit_field(
    input logic [31:0] d,
    input int          pos
  );
    bit_field = {3'h0, d[pos]};
  endfunction

  // state

  npc_pkg::npc_level_type level_q [NUM_SRC];
  npc_pkg::npc_level_type mask_q;
  logic                   enable_q;
  logic [`NPC_RESET_CAUSES-1:0] rstCause_q;
  logic [`NPC_VEC_W-1:0]  fetched_q;
  logic [NUM_SRC-1:0]     gatedOut_q;
  logic                   pendValid_q;
  logic [`NPC_VEC_W-1:0]  pendVec_q;
  logic [15:0]            pendAddr_q;
  logic                   rstVecReq_q;
  logic                   ack_q;
  logic [31:0]            rdDat_q;

  logic                   reqHit;
  logic                   wrStrobe;
  logic                   ctrlWr;
  logic                   rcauseWr;
  logic [LVL_WORDS-1:0]   levelWr;
  logic                   restoreReq;
  logic                   fetchOk;
  logic                   stackPush;
  logic                   stackPop;
  npc_pkg::npc_level_type stackTop;
  logic                   stackEmpty;
  logic                   stackFull;
  logic [`NPC_STACK_DEPTH*2-1:0] stackWords;
  npc_pkg::npc_level_type effMask;
  logic [NUM_SRC-1:0]     rawReq;
  logic [NUM_SRC-1:0]     gatedD;
  logic [`NPC_VEC_W:0]    winner;
  logic [31:0]            lvlWord [LVL_WORDS];
  logic [31:0]            ctrlWord;
  logic [31:0]            rdMux;

  // register bus

  // one wait state: ack rises the cycle after the request is seen; the
  // write lands on the edge where the master samples ack
  assign reqHit   = wbReq.cyc & wbReq.stb;
  assign wrStrobe = reqHit & wbReq.we & ack_q;
  assign ctrlWr   = wrStrobe & (wbReq.adr == `NPC_OFS_CTRL);
  assign rcauseWr = wrStrobe & (wbReq.adr == `NPC_OFS_RCAUSE) & wbReq.sel[0];

  always_comb begin
    for (int w = 0; w < LVL_WORDS; w++) begin
      levelWr[w] = wrStrobe & (wbReq.adr == level_offset(w));
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= reqHit & ~ack_q;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdDat_q <= 32'h0000_0000;
    end else if (reqHit && !ack_q) begin
      rdDat_q <= wbReq.we ? 32'h0000_0000 : rdMux;
    end
  end

  // one driver for the whole answer struct
  assign wbRsp = '{ack: ack_q, dat: rdDat_q};

  // source levels

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_SRC; i++) level_q[i] <= `NPC_LEVEL_RST;
    end else begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (levelWr[i / `NPC_LEVELS_PER_WORD] &&
            wbReq.sel[(i % `NPC_LEVELS_PER_WORD) / 4]) begin
          level_q[i] <= wbReq.dat[(i % `NPC_LEVELS_PER_WORD) * 2 +: 2];
        end
      end
    end
  end

  always_comb begin
    for (int w = 0; w < LVL_WORDS; w++) begin
      lvlWord[w] = 32'h0000_0000;
      for (int j = 0; j < `NPC_LEVELS_PER_WORD; j++) begin
        if (w * `NPC_LEVELS_PER_WORD + j < NUM_SRC) begin
          lvlWord[w][j*2 +: 2] = level_q[w * `NPC_LEVELS_PER_WORD + j];
        end
      end
    end
  end

  // priority mask

  // fetch beats a restore in the same cycle; a restore beats a plain write
  assign fetchOk    = vectorFetchStrobe && (int'(fetchVector) < NUM_SRC);
  assign restoreReq = ctrlWr & wbReq.sel[0] &
                      wbReq.dat[`NPC_CTRL_RESTORE_BIT];
  assign stackPush  = fetchOk;
  assign stackPop   = restoreReq & ~fetchOk;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mask_q <= `NPC_MASK_RST;
    end else if (fetchOk) begin
      mask_q <= level_q[fetchVector];
    end else if (restoreReq) begin
      mask_q <= stackTop;
    end else if (ctrlWr && wbReq.sel[0]) begin
      mask_q <= wbReq.dat[`NPC_CTRL_MASK_LSB +: 2];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      enable_q <= `NPC_ENABLE_RST;
    end else if (ctrlWr && wbReq.sel[0]) begin
      enable_q <= wbReq.dat[`NPC_CTRL_ENABLE_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fetched_q <= '0;
    end else if (fetchOk) begin
      fetched_q <= fetchVector;
    end
  end

  npc_mask_stack #(
    .DEPTH    (`NPC_STACK_DEPTH)
  ) u_stack (
    .core_clk (core_clk),
    .resetn   (resetn),
    .push     (stackPush),
    .pushVal  (mask_q),
    .pop      (stackPop),
    .popVal   (stackTop),
    .empty    (stackEmpty),
    .full     (stackFull),
    .contents (stackWords)
  );

  // request gating

  assign effMask = stopMode ? `NPC_STOP_MASK : mask_q;

  always_comb begin
    rawReq    = srcReq;
    rawReq[0] = srcReq[0] | (|resetCause);
  end

  // reset and software interrupt are never held back by the mask
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      if (!enable_q || i < `NPC_NUM_FIXED) begin
        gatedD[i] = rawReq[i];
      end else begin
        gatedD[i] = rawReq[i] && (level_q[i] >= effMask);
      end
    end
  end

  assign winner = lowest_set(gatedD);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gatedOut_q <= '0;
    end else begin
      gatedOut_q <= gatedD;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pendValid_q <= 1'b0;
      pendVec_q   <= '0;
      pendAddr_q  <= `NPC_VEC_TOP_ADDR;
    end else begin
      pendValid_q <= winner[`NPC_VEC_W];
      pendVec_q   <= winner[`NPC_VEC_W-1:0];
      pendAddr_q  <= vec_addr(winner[`NPC_VEC_W-1:0]);
    end
  end

  // reset causes

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rstVecReq_q <= 1'b0;
    end else begin
      rstVecReq_q <= |resetCause;
    end
  end

  // sticky causes; a new cause wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rstCause_q <= '0;
    end else begin
      rstCause_q <= (rstCause_q &
                     ~(rcauseWr ? wbReq.dat[`NPC_RESET_CAUSES-1:0] : '0)) |
                    resetCause;
    end
  end

  // read decode

  always_comb begin
    ctrlWord = 32'h0000_0000;
    ctrlWord[`NPC_CTRL_MASK_LSB +: 2] = mask_q;
    ctrlWord[`NPC_CTRL_ENABLE_BIT]    = enable_q;
    ctrlWord[`NPC_CTRL_EMPTY_BIT]     = stackEmpty;
    ctrlWord[`NPC_CTRL_FULL_BIT]      = stackFull;
    ctrlWord[`NPC_CTRL_STOP_BIT]      = stopMode;
    ctrlWord[`NPC_CTRL_STACK_LSB +: `NPC_STACK_DEPTH*2] = stackWords;
  end

  always_comb begin
    rdMux = 32'h0000_0000;
    if (wbReq.adr == `NPC_OFS_CTRL) begin
      rdMux = ctrlWord;
    end else if (wbReq.adr == `NPC_OFS_VEC) begin
      rdMux[`NPC_VEC_NUM_LSB +: `NPC_VEC_W] = pendVec_q;
      rdMux[`NPC_VEC_VALID_BIT]             = pendValid_q;
      rdMux[`NPC_VEC_ADDR_LSB +: 16]        = pendAddr_q;
    end else if (wbReq.adr == `NPC_OFS_RCAUSE) begin
      rdMux[`NPC_RESET_CAUSES-1:0] = rstCause_q;
    end else if (wbReq.adr == `NPC_OFS_FETCHED) begin
      rdMux[`NPC_VEC_W-1:0] = fetched_q;
    end else begin
      for (int w = 0; w < LVL_WORDS; w++) begin
        if (wbReq.adr == level_offset(w)) rdMux = lvlWord[w];
      end
    end
  end

  // outputs

  assign gatedRequestOut = gatedOut_q;
  assign pendingValid    = pendValid_q;
  assign pendingVector   = pendVec_q;
  assign pendingVecAddr  = pendAddr_q;
  assign resetVectorReq  = rstVecReq_q;

endmodule
`default_nettype wire

// [logic/npc_mask_stack.sv]
`timescale 1ns/10ps
`default_nettype none
`include "npc_params.svh"
module npc_mask_stack #(
  parameter int DEPTH = `NPC_STACK_DEPTH
) (
  input  wire logic                  core_clk,   // bus clock
  input  wire logic                  resetn,     // async reset, active low
  input  wire logic                  push,       // save a mask
  input  wire npc_pkg::npc_level_type pushVal,   // mask being saved
  input  wire logic                  pop,        // restore a mask
  output npc_pkg::npc_level_type     popVal,     // newest saved mask
  output logic                       empty,      // nothing saved
  output logic                       full,       // all slots in use
  output logic [DEPTH*2-1:0]         contents    // slot 0 in low bits
);

  npc_pkg::npc_level_type slot_q [DEPTH];
  logic [$clog2(DEPTH+1)-1:0] count_q;

  // shift register: the oldest entry falls off the end on overflow
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) slot_q[i] <= `NPC_MASK_RST;
    end else if (push) begin
      slot_q[0] <= pushVal;
      for (int i = 1; i < DEPTH; i++) slot_q[i] <= slot_q[i-1];
    end else if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) slot_q[i] <= slot_q[i+1];
      slot_q[DEPTH-1] <= `NPC_MASK_RST;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= '0;
    end else if (push && !full) begin
      count_q <= count_q + 1'b1;
    end else if (pop && !push && !empty) begin
      count_q <= count_q - 1'b1;
    end
  end

  assign popVal = slot_q[0];
  assign empty  = (count_q == '0);
  assign full   = (count_q == ($clog2(DEPTH+1))'(DEPTH));

  always_comb begin
    contents = '0;
    for (int i = 0; i < DEPTH; i++) contents[i*2 +: 2] = slot_q[i];
  end

endmodule
`default_nettype wire

// [logic/npc_params.svh]
`ifndef NPC_PARAMS_SVH
`define NPC_PARAMS_SVH

`define NPC_ADR_W            8
`define NPC_OFS_CTRL         8'h00
`define NPC_OFS_VEC          8'h04
`define NPC_OFS_RCAUSE       8'h08
`define NPC_OFS_FETCHED      8'h0C
`define NPC_OFS_LEVEL        8'h10

`define NPC_CTRL_MASK_LSB    0
`define NPC_CTRL_RESTORE_BIT 2
`define NPC_CTRL_ENABLE_BIT  3
`define NPC_CTRL_EMPTY_BIT   4
`define NPC_CTRL_FULL_BIT    5
`define NPC_CTRL_STOP_BIT    6
`define NPC_CTRL_STACK_LSB   8

`define NPC_VEC_NUM_LSB      0
`define NPC_VEC_VALID_BIT    8
`define NPC_VEC_ADDR_LSB     16

`define NPC_STACK_DEPTH      4
`define NPC_NUM_SRC          40
`define NPC_NUM_FIXED        2
`define NPC_VEC_W            6
`define NPC_LEVEL_W          2
`define NPC_LEVELS_PER_WORD  16
`define NPC_RESET_CAUSES     8
`define NPC_VEC_TOP_ADDR     16'hFFFE

`define NPC_LEVEL_RST        2'h0
`define NPC_MASK_RST         2'h0
`define NPC_STOP_MASK        2'h0
`define NPC_ENABLE_RST       1'h0

`endif

// [logic/npc_pkg.sv]
`default_nettype none
`include "npc_params.svh"
package npc_pkg;

  typedef logic [`NPC_LEVEL_W-1:0] npc_level_type;

  typedef struct packed {
    logic                    cyc;
    logic                    stb;
    logic                    we;
    logic [`NPC_ADR_W-1:0]   adr;
    logic [3:0]              sel;
    logic [31:0]             dat;
  } npc_wb_req_type;

  typedef struct packed {
    logic                    ack;
    logic [31:0]             dat;
  } npc_wb_rsp_type;

endpackage
`default_nettype wire

// [tb/npc_core_model.sv]
`timescale 1ns/10ps
`default_nettype none
`include "npc_params.svh"
module npc_core_model (
  input  wire logic                  core_clk,          // bus clock
  input  wire logic                  resetn,            // async reset
  input  wire logic                  fetchGo,           // bench asks a fetch
  input  wire logic                  slowFetch,         // answer late
  input  wire logic                  pendingValid,      // request pending
  input  wire logic [`NPC_VEC_W-1:0] pendingVector,     // pending vector
  output logic                       vectorFetchStrobe, // fetch pulse
  output logic [`NPC_VEC_W-1:0]      fetchVector        // fetched vector
);
  logic [1:0] waitQ;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      vectorFetchStrobe <= 1'b0;
      fetchVector       <= '0;
      waitQ             <= 2'h0;
    end else begin
      vectorFetchStrobe <= 1'b0;
      if (fetchGo && pendingValid && !vectorFetchStrobe) begin
        if (slowFetch && waitQ != 2'h3) begin
          waitQ <= waitQ + 2'h1;
        end else begin
          vectorFetchStrobe <= 1'b1;
          fetchVector       <= pendingVector;
          waitQ             <= 2'h0;
        end
      end else if (!vectorFetchStrobe) begin
        // idle vector toggles so a stale value is never trusted
        fetchVector <= ~fetchVector;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/npc_ctrl_props.sv]
`timescale 1ns/10ps
`default_nettype none
`include "npc_params.svh"
module npc_ctrl_props #(
  parameter int NUM_SRC = `NPC_NUM_SRC
) (
  input wire logic                         core_clk,          // clock
  input wire logic                         resetn,            // reset
  input wire npc_pkg::npc_wb_req_type      wbReq,             // request
  input wire npc_pkg::npc_wb_rsp_type      wbRsp,             // answer
  input wire logic [NUM_SRC-1:0]           srcReq,            // sources
  input wire logic [`NPC_RESET_CAUSES-1:0] resetCause,        // causes
  input wire logic                         stopMode,          // stop
  input wire logic                         vectorFetchStrobe, // fetch
  input wire logic [`NPC_VEC_W-1:0]        fetchVector,       // fetched
  input wire logic [NUM_SRC-1:0]           gatedRequestOut,   // to core
  input wire logic                         pendingValid,      // pending
  input wire logic [`NPC_VEC_W-1:0]        pendingVector,     // vector
  input wire logic [15:0]                  pendingVecAddr,    // address
  input wire logic                         resetVectorReq     // reset vec
);
  logic [NUM_SRC-1:0]                      rawSrc;
  // any reset cause raises vector 0 as if its source were set
  assign rawSrc = {srcReq[NUM_SRC-1:1], srcReq[0] | (|resetCause)};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_ack_pulse: assert property (
    wbRsp.ack |=> !wbRsp.ack)
    else $error("ack held too long");
  a_ack_wait: assert property (
    $rose(wbReq.cyc && wbReq.stb) |=> wbRsp.ack)
    else $error("ack not after one wait state");
  a_write_zero: assert property (
    wbRsp.ack && wbReq.we |-> wbRsp.dat == '0)
    else $error("write answer carries data");
  a_no_spurious: assert property (
    (gatedRequestOut & ~$past(rawSrc)) == '0)
    else $error("request passed without source");
  a_fixed_bypass: assert property (
    gatedRequestOut[1:0] == $past(rawSrc[1:0]))
    else $error("fixed vector gated");
  a_pend_addr: assert property (
    pendingValid |-> pendingVecAddr == 16'hFFFE - {pendingVector, 1'b0})
    else $error("vector address wrong");
  a_pend_lowest: assert property (
    pendingValid |-> gatedRequestOut[pendingVector] &&
      (gatedRequestOut & ~({NUM_SRC{1'b1}} << pendingVector)) == '0)
    else $error("pending vector not the lowest");
  a_pend_valid: assert property (
    pendingValid == |gatedRequestOut)
    else $error("pending flag wrong");
  a_reset_vec: assert property (
    resetVectorReq == $past(|resetCause))
    else $error("reset vector request wrong");
  a_stop_pass: assert property (
    $past(stopMode) |-> gatedRequestOut == $past(rawSrc))
    else $error("stop mode gated a request");
endmodule
bind npc_ctrl npc_ctrl_props #(
  .NUM_SRC           (NUM_SRC)
) i_props (
  .core_clk          (core_clk),
  .resetn            (resetn),
  .wbReq             (wbReq),
  .wbRsp             (wbRsp),
  .srcReq            (srcReq),
  .resetCause        (resetCause),
  .stopMode          (stopMode),
  .vectorFetchStrobe (vectorFetchStrobe),
  .fetchVector       (fetchVector),
  .gatedRequestOut   (gatedRequestOut),
  .pendingValid      (pendingValid),
  .pendingVector     (pendingVector),
  .pendingVecAddr    (pendingVecAddr),
  .resetVectorReq    (resetVectorReq)
);
`default_nettype wire

// [tb/npc_ctrl_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "npc_params.svh"
module npc_ctrl_tb;
  logic                    core_clk = 1'b0;
  logic                    resetn = 1'b0;
  npc_pkg::npc_wb_req_type wbReq = '0;
  npc_pkg::npc_wb_rsp_type wbRsp;
  logic [39:0]             srcReq = '0;
  logic [7:0]              resetCause = '0;
  logic                    stopMode = 1'b0;
  logic                    fetchGo = 1'b0;
  logic                    slowFetch = 1'b0;
  logic                    strobe;
  logic [5:0]              fetchVec;
  logic [5:0]              pendVec;
  logic [39:0]             gated;
  logic                    pendValid;
  logic                    resetVec;
  logic [15:0]             pendAddr;
  logic [31:0]             rdat;
  int                      failures = 0;
  int                      check_count = 0;
  always #50 core_clk = ~core_clk;
  npc_ctrl i_dut (
    .core_clk          (core_clk),
    .resetn            (resetn),
    .wbReq             (wbReq),
    .wbRsp             (wbRsp),
    .srcReq            (srcReq),
    .resetCause        (resetCause),
    .stopMode          (stopMode),
    .vectorFetchStrobe (strobe),
    .fetchVector       (fetchVec),
    .gatedRequestOut   (gated),
    .pendingValid      (pendValid),
    .pendingVector     (pendVec),
    .pendingVecAddr    (pendAddr),
    .resetVectorReq    (resetVec)
  );
  npc_core_model i_core (
    .core_clk          (core_clk),
    .resetn            (resetn),
    .fetchGo           (fetchGo),
    .slowFetch         (slowFetch),
    .pendingValid      (pendValid),
    .pendingVector     (pendVec),
    .vectorFetchStrobe (strobe),
    .fetchVector       (fetchVec)
  );
  task automatic test_done;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [39:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // one classic cycle; an idle edge follows so cyc stays low a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge core_clk);
      n++;
    end while (wbRsp.ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      test_done;
    end
    rdat = wbRsp.dat;
    wbReq <= '0;
    @(posedge core_clk);
  endtask
  task automatic fetch(input logic slow);
    int n;
    n = 0;
    fetchGo   <= 1'b1;
    slowFetch <= slow;
    do begin
      @(posedge core_clk);
      n++;
    end while (strobe !== 1'b1 && n < 30);
    if (n >= 30) begin
      failures++;
      test_done;
    end
    fetchGo <= 1'b0;
  endtask
  task automatic t_reset;
    wb(1'b0, `NPC_OFS_CTRL, '0);
    check("ctrl", rdat, 32'h10);
    wb(1'b0, `NPC_OFS_LEVEL, '0);
    check("level", rdat, 32'h0);
    wb(1'b0, 8'h40, '0);
    check("unmapped", rdat, 32'h0);
  endtask
  task automatic t_levels;
    wb(1'b1, `NPC_OFS_LEVEL, 32'hE4E4E4E4);
    wb(1'b1, `NPC_OFS_LEVEL + 8'h04, 32'h1B1B1B1B);
    wb(1'b0, `NPC_OFS_LEVEL, '0);
    check("level0", rdat, 32'hE4E4E4E4);
    wb(1'b0, `NPC_OFS_LEVEL + 8'h04, '0);
    check("level1", rdat, 32'h1B1B1B1B);
  endtask
  task automatic t_passthru;
    srcReq <= 40'h80_0010_0080;
    tick(3);
    check("bypass", gated, 40'h80_0010_0080);
    check("pending", pendVec, 6'h07);
    check("vecaddr", pendAddr, 16'hFFF0);
    check("pendvalid", pendValid, 1'b1);
    wb(1'b0, `NPC_OFS_VEC, '0);
    check("vecreg", rdat, 32'hFFF0_0107);
  endtask
  // sources 0-15 hold level n%4; vectors 0 and 1 always pass
  task automatic t_gating;
    logic [15:0] gateExp [4];
    gateExp = '{16'hFFFF, 16'hEEEF, 16'hCCCF, 16'h888B};
    srcReq <= 40'hFFFF;
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, `NPC_OFS_CTRL, 32'h8 | m);
      tick(2);
      check("gated", gated, {24'h0, gateExp[m]});
    end
  endtask
  task automatic t_stop;
    stopMode <= 1'b1;
    tick(3);
    check("stopgate", gated, 40'hFFFF);
    wb(1'b0, `NPC_OFS_CTRL, '0);
    check("stopctrl", rdat, 32'h5B);
    stopMode <= 1'b0;
    srcReq   <= '0;
  endtask
  task automatic t_nest;
    int srcs [4];
    logic [1:0] lvl [4];
    srcs = '{5, 6, 7, 11};
    lvl  = '{2'h1, 2'h2, 2'h3, 2'h3};
    wb(1'b1, `NPC_OFS_CTRL, 32'h8);
    for (int i = 0; i < 4; i++) begin
      srcReq <= 40'h1 << srcs[i];
      fetch(i[0]);
      srcReq <= '0;
      wb(1'b0, `NPC_OFS_CTRL, '0);
      check("fetchmask", rdat[1:0], lvl[i]);
    end
    check("stackfull", rdat, 32'h1B2B);
    wb(1'b0, `NPC_OFS_FETCHED, '0);
    check("fetched", rdat, 32'h0B);
    srcReq <= 40'h1 << 5;
    tick(3);
    check("blocked", gated, 40'h0);
    srcReq <= '0;
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, `NPC_OFS_CTRL, 32'hC);
      wb(1'b0, `NPC_OFS_CTRL, '0);
      check("popmask", rdat[1:0], 2'h3 - i[1:0]);
    end
    check("emptied", rdat[7:0], 8'h18);
    wb(1'b1, `NPC_OFS_CTRL, 32'hA);
    wb(1'b0, `NPC_OFS_CTRL, '0);
    check("maskwrite", rdat[7:0], 8'h1A);
    // restore on an empty stack wins over the mask field and loads 0
    wb(1'b1, `NPC_OFS_CTRL, 32'hE);
    wb(1'b0, `NPC_OFS_CTRL, '0);
    check("emptypop", rdat[7:0], 8'h18);
  endtask
  task automatic t_rcause;
    for (int i = 0; i < 8; i++) begin
      resetCause <= 8'h1 << i;
      tick(2);
      check("resetvec", resetVec, 1'b1);
      check("rcausegate", gated[0], 1'b1);
      resetCause <= '0;
      tick(2);
      check("resetvec", resetVec, 1'b0);
    end
    wb(1'b0, `NPC_OFS_RCAUSE, '0);
    check("rcause", rdat, 32'hFF);
    wb(1'b1, `NPC_OFS_RCAUSE, 32'hFF);
    wb(1'b0, `NPC_OFS_RCAUSE, '0);
    check("rcauseclr", rdat, 32'h0);
  endtask
  initial begin
    tick(10);
    resetn <= 1'b1;
    tick(1);
    t_reset;
    t_levels;
    t_passthru;
    t_gating;
    t_stop;
    t_nest;
    t_rcause;
    test_done;
  end
endmodule
`default_nettype wire
